// >>> core/rts_pkg.sv
package rts_pkg;

	// ------------------------------------------------------------
	// table limits
	// ------------------------------------------------------------
	localparam int ROW_MIN = 1;
	localparam int MAX_ROWS = 32;
	localparam int COL_MIN = 1;
	localparam int MAX_COLS = 6;
	localparam int KEY_MIN = 1;
	localparam int BUF_WORDS = 384;
	localparam int TIDX_W = 9;

	// valid element range of the word memory, in 16-bit words
	localparam logic [32:0] MEM_WORDS = 33'h0_0000_8000;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SRC = 8'h04;
	localparam logic [7:0] REG_DST = 8'h08;
	localparam logic [7:0] REG_ROWS = 8'h0C;
	localparam logic [7:0] REG_COLS = 8'h10;
	localparam logic [7:0] REG_KEY = 8'h14;
	localparam logic [7:0] REG_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h20;
	localparam logic [7:0] REG_ERR = 8'h24;

	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_DESC_BIT = 1;
	localparam int CTRL_WIDE_BIT = 2;
	localparam int CTRL_W = 3;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_W = 2;

	// ------------------------------------------------------------
	// error codes
	// ------------------------------------------------------------
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_ADDR = 16'h1A31;
	localparam logic [15:0] ERR_PARAM = 16'h1A32;

	// ------------------------------------------------------------
	// engine states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_LOAD = 6'b00_0010,
		ST_WAIT = 6'b00_0100,
		ST_SEARCH = 6'b00_1000,
		ST_WRITE = 6'b01_0000,
		ST_DONE = 6'b10_0000
	} rts_state_t;

endpackage : rts_pkg

// >>> core/rts_key_cmp.sv
`timescale 1ns/100ps
`default_nettype none

module rts_key_cmp (
	// keys
	input wire logic [31:0] key_a,
	input wire logic [31:0] key_b,
	// mode
	input wire logic wide,
	input wire logic desc,
	// result: key_a must come strictly before key_b
	output logic a_first
);

	logic signed [31:0] sa;
	logic signed [31:0] sb;

	// narrow keys are signed 16-bit words
	always_comb
	begin
		sa = wide ? key_a : {{16{key_a[15]}}, key_a[15:0]};
		sb = wide ? key_b : {{16{key_b[15]}}, key_b[15:0]};
		a_first = desc ? (sa > sb) : (sa < sb);
	end

endmodule : rts_key_cmp

`default_nettype wire

// >>> core/rts_sort_core.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module rts_sort_core (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// controller scan
	input wire logic scan_tick,
	// word memory
	output logic [15:0] mem_addr,
	output logic mem_rd,
	input wire logic [15:0] mem_rdata,
	output logic mem_wr,
	output logic [15:0] mem_wdata,
	// flags
	output logic execution_complete_flag,
	output logic operation_error_flag,
	output logic [15:0] error_code_word,
	output logic irq
);

	import rts_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	rts_state_t state_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [31:0] src_q;
	logic [31:0] dst_q;
	logic [31:0] rows_q;
	logic [31:0] cols_q;
	logic [31:0] key_q;
	logic [IRQ_W-1:0] istat_q;
	logic [IRQ_W-1:0] imask_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic en_prev_q;
	logic pend_q;
	logic done_q;
	logic err_q;
	logic [15:0] errc_q;
	logic done_ev_q;
	logic err_ev_q;
	logic [15:0] mem_addr_q;
	logic mem_rd_q;
	logic mem_wr_q;
	logic [15:0] mem_wdata_q;
	logic [TIDX_W-1:0] ld_idx_q;
	logic [TIDX_W-1:0] rd_idx_q;
	logic [TIDX_W-1:0] cap_idx_q;
	logic cap_v_q;
	logic [15:0] tbl_q [BUF_WORDS];
	logic [5:0] nrows_q;
	logic [3:0] rw_q;
	logic [3:0] koff_q;
	logic [TIDX_W-1:0] total_q;
	logic wide_q;
	logic desc_q;
	logic [15:0] sbase_q;
	logic [15:0] dbase_q;
	logic [MAX_ROWS-1:0] placed_q;
	logic [5:0] pos_q;
	logic [4:0] srch_q;
	logic [4:0] best_q;
	logic [31:0] best_key_q;
	logic best_v_q;
	logic [3:0] wj_q;

	logic en;
	logic en_rise;
	logic wide;
	logic [31:0] e_src;
	logic [31:0] e_dst;
	logic [31:0] e_rows;
	logic [31:0] e_cols;
	logic [31:0] e_key;
	logic param_ok;
	logic addr_ok;
	logic [3:0] rw;
	logic [TIDX_W-1:0] total;
	logic [TIDX_W-1:0] kidx;
	logic [TIDX_W-1:0] kidx_hi;
	logic [31:0] key_i;
	logic a_first;
	logic take;
	logic consume;
	logic [TIDX_W-1:0] out_base;
	logic [TIDX_W-1:0] best_base;
	logic [IRQ_W-1:0] w1c;
	logic [IRQ_W-1:0] ev;

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign mem_addr = mem_addr_q;
	assign mem_rd = mem_rd_q;
	assign mem_wr = mem_wr_q;
	assign mem_wdata = mem_wdata_q;
	assign execution_complete_flag = done_q;
	assign operation_error_flag = err_q;
	assign error_code_word = errc_q;

	// ------------------------------------------------------------
	// operand check
	// ------------------------------------------------------------
	assign en = ctrl_q[CTRL_EN_BIT];
	assign en_rise = en & ~en_prev_q;
	assign wide = ctrl_q[CTRL_WIDE_BIT];

	always_comb
	begin
		// narrow operands use only the low word
		e_src = wide ? src_q : {16'h0000, src_q[15:0]};
		e_dst = wide ? dst_q : {16'h0000, dst_q[15:0]};
		e_rows = wide ? rows_q : {16'h0000, rows_q[15:0]};
		e_cols = wide ? cols_q : {16'h0000, cols_q[15:0]};
		e_key = wide ? key_q : {16'h0000, key_q[15:0]};
		param_ok = (e_rows >= 32'(ROW_MIN)) && (e_rows <= 32'(MAX_ROWS))
			&& (e_cols >= 32'(COL_MIN)) && (e_cols <= 32'(MAX_COLS))
			&& (e_key >= 32'(KEY_MIN)) && (e_key <= e_cols);
		rw = wide ? {e_cols[2:0], 1'b0} : {1'b0, e_cols[2:0]};
		total = TIDX_W'(e_rows[5:0] * rw);
		// table must end inside the element range
		addr_ok = ({1'b0, e_src} + 33'(total) <= MEM_WORDS)
			&& ({1'b0, e_dst} + 33'(total) <= MEM_WORDS);
	end

	// ------------------------------------------------------------
	// key fetch and compare
	// ------------------------------------------------------------
	always_comb
	begin
		kidx = TIDX_W'(srch_q * rw_q) + TIDX_W'(koff_q);
		kidx_hi = TIDX_W'(kidx + 9'h001);
		key_i = wide_q ? {tbl_q[kidx_hi], tbl_q[kidx]} : {16'h0000, tbl_q[kidx]};
		out_base = TIDX_W'(pos_q * rw_q);
		best_base = TIDX_W'(best_q * rw_q);
	end

	rts_key_cmp u_cmp (
		.key_a(key_i),
		.key_b(best_key_q),
		.wide(wide_q),
		.desc(desc_q),
		.a_first(a_first)
	);

	// strict compare in index order keeps ties stable
	assign take = ~placed_q[srch_q] & (~best_v_q | a_first);
	assign consume = (state_q == ST_WAIT) & pend_q;

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q <= '0;
			src_q <= '0;
			dst_q <= '0;
			rows_q <= '0;
			cols_q <= '0;
			key_q <= '0;
			imask_q <= '0;
			en_prev_q <= 1'b0;
		end
		else
		begin
			en_prev_q <= en;
			if (reg_wr)
			begin
				case (reg_addr)
					REG_CTRL: ctrl_q <= reg_wdata[CTRL_W-1:0];
					REG_SRC: src_q <= reg_wdata;
					REG_DST: dst_q <= reg_wdata;
					REG_ROWS: rows_q <= reg_wdata;
					REG_COLS: cols_q <= reg_wdata;
					REG_KEY: key_q <= reg_wdata;
					REG_IRQ_MASK: imask_q <= reg_wdata[IRQ_W-1:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_q <= '0;
		else if (reg_rd)
		begin
			case (reg_addr)
				REG_CTRL: rdata_q <= 32'(ctrl_q);
				REG_SRC: rdata_q <= src_q;
				REG_DST: rdata_q <= dst_q;
				REG_ROWS: rdata_q <= rows_q;
				REG_COLS: rdata_q <= cols_q;
				REG_KEY: rdata_q <= key_q;
				REG_STAT: rdata_q <= 32'({~(state_q == ST_IDLE || state_q == ST_DONE), err_q, done_q});
				REG_IRQ_STAT: rdata_q <= 32'(istat_q);
				REG_IRQ_MASK: rdata_q <= 32'(imask_q);
				REG_ERR: rdata_q <= 32'(errc_q);
				default: rdata_q <= '0;
			endcase
		end
		else
			rdata_q <= '0;
	end

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	assign w1c = (reg_wr && reg_addr == REG_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0;
	assign ev = {err_ev_q, done_ev_q};

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			istat_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			// a new event beats a clear in the same cycle
			istat_q <= (istat_q & ~w1c) | ev;
			irq_q <= |(istat_q & imask_q);
		end
	end

	// ------------------------------------------------------------
	// scan pacing
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pend_q <= 1'b0;
		else
			pend_q <= scan_tick | (pend_q & ~consume);
	end

	// ------------------------------------------------------------
	// table snapshot
	// ------------------------------------------------------------
	// whole table is copied first, so in-place sorting is safe
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cap_v_q <= 1'b0;
			cap_idx_q <= '0;
		end
		else
		begin
			cap_v_q <= mem_rd_q;
			cap_idx_q <= rd_idx_q;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (cap_v_q)
			tbl_q[cap_idx_q] <= mem_rdata;
	end

	// ------------------------------------------------------------
	// sort engine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ST_IDLE;
			done_q <= 1'b0;
			err_q <= 1'b0;
			errc_q <= ERR_NONE;
			done_ev_q <= 1'b0;
			err_ev_q <= 1'b0;
			mem_addr_q <= '0;
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_wdata_q <= '0;
			ld_idx_q <= '0;
			rd_idx_q <= '0;
			nrows_q <= '0;
			rw_q <= '0;
			koff_q <= '0;
			total_q <= '0;
			wide_q <= 1'b0;
			desc_q <= 1'b0;
			sbase_q <= '0;
			dbase_q <= '0;
			placed_q <= '0;
			pos_q <= '0;
			srch_q <= '0;
			best_q <= '0;
			best_key_q <= '0;
			best_v_q <= 1'b0;
			wj_q <= '0;
		end
		else
		begin
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			done_ev_q <= 1'b0;
			err_ev_q <= 1'b0;
			if (!en)
			begin
				// dropping enable aborts and rearms
				state_q <= ST_IDLE;
				done_q <= 1'b0;
			end
			else
			begin
				case (state_q)
					ST_IDLE:
					begin
						if (en_rise && !param_ok)
						begin
							err_q <= 1'b1;
							errc_q <= ERR_PARAM;
							err_ev_q <= 1'b1;
						end
						else if (en_rise && !addr_ok)
						begin
							err_q <= 1'b1;
							errc_q <= ERR_ADDR;
							err_ev_q <= 1'b1;
						end
						else if (en_rise)
						begin
							// operands latched here, a run ignores later writes except one that clears EN
							err_q <= 1'b0;
							errc_q <= ERR_NONE;
							nrows_q <= e_rows[5:0];
							rw_q <= rw;
							koff_q <= wide ? 4'((e_key[2:0] - 3'h1) * 2) : 4'(e_key[2:0] - 3'h1);
							total_q <= total;
							wide_q <= wide;
							desc_q <= ctrl_q[CTRL_DESC_BIT];
							sbase_q <= e_src[15:0];
							dbase_q <= e_dst[15:0];
							ld_idx_q <= '0;
							placed_q <= '0;
							pos_q <= '0;
							state_q <= ST_LOAD;
						end
					end
					ST_LOAD:
					begin
						if (ld_idx_q != total_q)
						begin
							mem_rd_q <= 1'b1;
							mem_addr_q <= 16'(sbase_q + 16'(ld_idx_q));
							rd_idx_q <= ld_idx_q;
							ld_idx_q <= TIDX_W'(ld_idx_q + 9'h001);
						end
						else if (!mem_rd_q && !cap_v_q)
							state_q <= ST_WAIT;
					end
					ST_WAIT:
					begin
						if (pend_q)
						begin
							srch_q <= '0;
							best_v_q <= 1'b0;
							state_q <= ST_SEARCH;
						end
					end
					ST_SEARCH:
					begin
						if (take)
						begin
							best_q <= srch_q;
							best_key_q <= key_i;
							best_v_q <= 1'b1;
						end
						if (6'(srch_q) == 6'(nrows_q - 6'h01))
						begin
							wj_q <= '0;
							state_q <= ST_WRITE;
						end
						else
							srch_q <= 5'(srch_q + 5'h01);
					end
					ST_WRITE:
					begin
						// all columns of the chosen row move together
						mem_wr_q <= 1'b1;
						mem_addr_q <= 16'(dbase_q + 16'(out_base) + 16'(wj_q));
						mem_wdata_q <= tbl_q[TIDX_W'(best_base + TIDX_W'(wj_q))];
						if (wj_q == 4'(rw_q - 4'h1))
						begin
							placed_q[best_q] <= 1'b1;
							pos_q <= 6'(pos_q + 6'h01);
							if (pos_q == 6'(nrows_q - 6'h01))
							begin
								done_q <= 1'b1;
								done_ev_q <= 1'b1;
								state_q <= ST_DONE;
							end
							else
								state_q <= ST_WAIT;
						end
						else
							wj_q <= 4'(wj_q + 4'h1);
					end
					ST_DONE: ;
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

endmodule : rts_sort_core

`default_nettype wire

// >>> tb/rts_sort_properties.sv
`timescale 1ns/100ps
`default_nettype none

module rts_sort_props
	import rts_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// memory and flags
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic execution_complete_flag,
	input wire logic operation_error_flag,
	input wire logic [15:0] error_code_word
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// control write history
	// ----------------------------------------
	logic ctl_wr_q;
	logic ctl_wr_q2;
	// the flag may lag the write by up to two edges
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl_wr_q <= 1'b0;
			ctl_wr_q2 <= 1'b0;
		end
		else
		begin
			ctl_wr_q <= reg_wr && (reg_addr == REG_CTRL);
			ctl_wr_q2 <= ctl_wr_q;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_rd_burst;
		mem_rd ##1 mem_rd;
	endsequence
	sequence s_wr_burst;
		mem_wr ##1 mem_wr;
	endsequence

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
	property p_rd_seq;
		s_rd_burst |-> mem_addr == $past(mem_addr) + 16'h0001;
	endproperty
	a_rd_seq: assert property (p_rd_seq) else $error("load address skipped");
	property p_wr_seq;
		s_wr_burst |-> mem_addr == $past(mem_addr) + 16'h0001;
	endproperty
	a_wr_seq: assert property (p_wr_seq) else $error("row write address skipped");
	property p_done_after_wr;
		$rose(execution_complete_flag) |-> mem_wr;
	endproperty
	a_done_after_wr: assert property (p_done_after_wr) else $error("done without write");
	property p_done_drop;
		$fell(execution_complete_flag) |-> ctl_wr_q || ctl_wr_q2;
	endproperty
	a_done_drop: assert property (p_done_drop) else $error("done dropped alone");
	property p_err_excl;
		operation_error_flag |-> !execution_complete_flag;
	endproperty
	a_err_excl: assert property (p_err_excl) else $error("error and done together");
	property p_err_code;
		operation_error_flag |-> error_code_word == ERR_ADDR || error_code_word == ERR_PARAM;
	endproperty
	a_err_code: assert property (p_err_code) else $error("bad error code");
	property p_no_mem_err;
		operation_error_flag && $past(operation_error_flag) |-> !mem_rd && !mem_wr;
	endproperty
	a_no_mem_err: assert property (p_no_mem_err) else $error("memory used on error");
	property p_mem_excl;
		!(mem_rd && mem_wr);
	endproperty
	a_mem_excl: assert property (p_mem_excl) else $error("read and write at once");
endmodule : rts_sort_props

bind rts_sort_core rts_sort_props u_props (
	.core_clk(core_clk),
	.resetn(resetn),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.mem_addr(mem_addr),
	.mem_rd(mem_rd),
	.mem_wr(mem_wr),
	.execution_complete_flag(execution_complete_flag),
	.operation_error_flag(operation_error_flag),
	.error_code_word(error_code_word)
);

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
	import rts_pkg::*;
	logic core_clk, resetn, reg_wr, reg_rd, scan_tick, mem_rd, mem_wr, irq;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [15:0] mem_addr, mem_rdata, mem_wdata, error_code_word;
	logic execution_complete_flag, operation_error_flag;
	logic [15:0] mem [0:65535];
	logic [15:0] orig [0:383];
	int mismatches, checked;

	rts_sort_core dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scan_tick(scan_tick), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .irq(irq),
		.execution_complete_flag(execution_complete_flag),
		.operation_error_flag(operation_error_flag), .error_code_word(error_code_word));

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// word memory; idle read data is junk so stale words never look valid
	always @(posedge core_clk)
	begin
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_addr;
	end

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rdr(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr
	task tick;
		@(posedge core_clk);
		scan_tick <= 1'b1;
		@(posedge core_clk);
		scan_tick <= 1'b0;
	endtask : tick
	function automatic logic signed [31:0] key_of(int o, int w);
		return (w == 2) ? {orig[o + 1], orig[o]} : {{16{orig[o][15]}}, orig[o]};
	endfunction : key_of

	// ----------------------------------------
	// run one sort and compare with a stable reference
	// ----------------------------------------
	task automatic sort_case(input logic [15:0] src, dst, input int rows, cols, key,
		input logic desc, wide);
		int w;
		int rw;
		int pos;
		logic signed [31:0] ki, kj;
		w = wide ? 2 : 1;
		rw = cols * w;
		for (int k = 0; k < rows * rw; k++)
			orig[k] = mem[src + k];
		wr(REG_SRC, {16'h0000, src});
		wr(REG_DST, {16'h0000, dst});
		wr(REG_ROWS, 32'(rows));
		wr(REG_COLS, 32'(cols));
		wr(REG_KEY, 32'(key));
		wr(REG_CTRL, 32'h0000_0000);
		wr(REG_CTRL, {29'h0000_0000, wide, desc, 1'b1});
		repeat (rows * rw + 4) @(posedge core_clk);
		rdr(REG_STAT);
		chk(rd[2:0], 3'b100, "busy");
		for (int i = 0; i < rows; i++)
		begin
			chk(execution_complete_flag, 1'b0, "done early");
			tick();
			repeat (rows + rw + 8) @(posedge core_clk);
		end
		for (int t = 0; t < 50 && execution_complete_flag !== 1'b1; t++)
			@(posedge core_clk);
		chk(execution_complete_flag, 1'b1, "done");
		chk(operation_error_flag, 1'b0, "error flag");
		rdr(REG_STAT);
		chk(rd[2:0], 3'b001, "status");
		for (int i = 0; i < rows; i++)
		begin
			pos = 0;
			ki = key_of(i * rw + (key - 1) * w, w);
			for (int j = 0; j < rows; j++)
			begin
				kj = key_of(j * rw + (key - 1) * w, w);
				if ((desc ? kj > ki : kj < ki) || (kj == ki && j < i))
					pos++;
			end
			for (int c = 0; c < rw; c++)
				chk(mem[dst + pos * rw + c], orig[i * rw + c], "row");
		end
	endtask : sort_case

	task automatic err_case(input logic [15:0] src, dst, input int rows, cols, key,
		input logic [15:0] code);
		mem[dst] = 16'h5A5A;
		wr(REG_IRQ_STAT, 32'h0000_0002);
		wr(REG_SRC, {16'h0000, src});
		wr(REG_DST, {16'h0000, dst});
		wr(REG_ROWS, 32'(rows));
		wr(REG_COLS, 32'(cols));
		wr(REG_KEY, 32'(key));
		wr(REG_CTRL, 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0001);
		repeat (4) @(posedge core_clk);
		chk(operation_error_flag, 1'b1, "error flag");
		chk(error_code_word, code, "error code");
		chk(execution_complete_flag, 1'b0, "done on error");
		chk(mem[dst], 16'h5A5A, "dest touched");
		chk(irq, 1'b0, "masked irq");
		rdr(REG_ERR);
		chk(rd, {16'h0000, code}, "error reg");
		rdr(REG_IRQ_STAT);
		chk(rd[1], 1'b1, "fresh error event");
	endtask : err_case

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset_regs;
		rdr(REG_CTRL);
		chk(rd, 32'h0000_0000, "ctrl reset");
		rdr(REG_ERR);
		chk(rd, 32'h0000_0000, "err reset");
		wr(8'h3C, 32'hFFFF_FFFF);
		rdr(8'h3C);
		chk(rd, 32'h0000_0000, "unmapped");
	endtask : t_reset_regs
	task t_example;
		for (int k = 0; k < 9; k++)
			mem[16'h0100 + k] = 16'({16'h0001, 16'h0002, 16'h0008, 16'h0002, 16'h0006,
				16'h0007, 16'h0003, 16'h0004, 16'h0003} >> (16 * (8 - k)));
		wr(REG_IRQ_MASK, 32'h0000_0003);
		sort_case(16'h0100, 16'h0200, 3, 3, 2, 1'b0, 1'b0);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b1, "irq on done");
		rdr(REG_IRQ_STAT);
		chk(rd[1:0], 2'b01, "irq status");
		wr(REG_IRQ_STAT, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0, "irq cleared");
		wr(REG_IRQ_MASK, 32'h0000_0000);
	endtask : t_example
	task t_desc_ties;
		for (int k = 0; k < 5; k++)
		begin
			mem[16'h0300 + 2 * k] = 16'({16'h0005, 16'hFFFD, 16'h0005, 16'h0000, 16'hFFFD} >> (16 * (4 - k)));
			mem[16'h0301 + 2 * k] = 16'(k);
		end
		sort_case(16'h0300, 16'h0300, 5, 2, 1, 1'b1, 1'b0);
	endtask : t_desc_ties
	task t_wide_full;
		for (int k = 0; k < 12; k++)
			mem[16'h0400 + k] = 16'(k * 40503);
		sort_case(16'h0400, 16'h0500, 3, 2, 2, 1'b0, 1'b1);
		for (int k = 0; k < 192; k++)
			mem[16'h1000 + k] = 16'((k * 7) % 13 - 6);
		sort_case(16'h1000, 16'h2000, 32, 6, 6, 1'b0, 1'b0);
	endtask : t_wide_full
	task t_errors;
		err_case(16'h0100, 16'h0600, 0, 2, 1, ERR_PARAM);
		err_case(16'h0100, 16'h0600, 33, 2, 1, ERR_PARAM);
		err_case(16'h0100, 16'h0600, 2, 0, 1, ERR_PARAM);
		err_case(16'h0100, 16'h0600, 2, 7, 1, ERR_PARAM);
		err_case(16'h0100, 16'h0600, 2, 2, 0, ERR_PARAM);
		err_case(16'h0100, 16'h0600, 2, 2, 3, ERR_PARAM);
		err_case(16'h7FFF, 16'h0600, 1, 2, 1, ERR_ADDR);
		err_case(16'h0100, 16'h7FFF, 1, 2, 1, ERR_ADDR);
		err_case(16'hFFF0, 16'h0600, 33, 2, 1, ERR_PARAM);
		wr(REG_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b1, "error irq");
		wr(REG_IRQ_STAT, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0, "error irq cleared");
	endtask : t_errors

	task print_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, scan_tick} = '0;
		mismatches = 0;
		checked = 0;
		resetn = 1'b0;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset_regs();
		t_example();
		t_errors();
		t_desc_ties();
		t_wide_full();
		print_verdict();
	end

	// whole run needs a few thousand cycles
	initial
	begin
		repeat (30000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
endmodule : tb

`default_nettype wire
